// File: logic/ftbsm_mapper.v
// Summary of operation
// R01 - three-bit channel position picks one of eight stream positions per input slot
// R02 - stream select zero lands slot in audio channel 32 plus position
// R03 - stream select one lands slot in audio channel 40 plus position
// R04 - byte field 00..11 writes channel bits 31:24, 23:16, 15:8, 7:0
// R05 - each channel is four byte lanes; a slot fills only its chosen lane
// R06 - 64 output slot map registers at consecutive indices
// R07 - output slots 0-31 on first output pin, 32-63 on second
// R08 - output slot carries one byte chosen by low six map bits
// R09 - reset clears all output and input slot map registers to zero
// R10 - stream select zero takes first input pin, one takes second input pin
// R11 - input slot with use bit clear is ignored, else byte is stored
// R12 - disabled output slot is high impedance or low per idle_high_impedance setting
// R13 - input map index n serves slot n mod 32, each of its two entries picks its pin by stream select
`timescale 1ns/100ps
`include "ftbsm_defs.vh"

module ftbsm_mapper #(
  parameter ADDR_W = 18
) (
  // clock, reset, enable
  input wire core_clk,
  input wire reset_n,
  input wire clk_en,
  // avalon-mm slave, byte addressed
  input wire [ADDR_W-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // serial link pins, asynchronous
  input wire tdm_bclk,
  input wire tdm_fsync,
  input wire first_flex_input_pin,
  input wire second_flex_input_pin,
  // serial output pins
  output reg first_flex_output_pin_o,
  output reg first_flex_output_pin_oe,
  output reg second_flex_output_pin_o,
  output reg second_flex_output_pin_oe,
  // audio channel words, 16 channels of 32 bits, channel 32/serial 0 lowest
  input wire [511:0] ser_out_chan_data,
  output reg [511:0] flex_in_chan_data
);

  localparam [15:0] IN_BASE = `FTBSM_IN_MAP_BASE;
  localparam [15:0] OUT_BASE = `FTBSM_OUT_MAP_BASE;
  localparam [15:0] CHAN_BASE = `FTBSM_CHAN_BASE_INDEX;
  localparam [15:0] CTRL_IDX = `FTBSM_CTRL_INDEX;

  // ==========================================================
  // helpers
  function [7:0] rev8;
    input [7:0] b;
    integer k;
    begin
      for (k = 0; k < 8; k = k + 1)
        rev8[k] = b[7-k];
    end
  endfunction

  // bit offset of a lane: byte 0 is the most significant lane
  function [8:0] lane_ofs;
    input [3:0] ch;
    input [1:0] bp;
    begin
      lane_ofs = {ch, ~bp, 3'b000}; // [R04] [R05]
    end
  endfunction

  function [15:0] merge16;
    input [15:0] old;
    input [31:0] wd;
    input [3:0] be;
    begin
      merge16[7:0] = be[0] ? wd[7:0] : old[7:0];
      merge16[15:8] = be[1] ? wd[15:8] : old[15:8];
    end
  endfunction

  // ==========================================================
  // registers
  reg [15:0] in_map_reg [0:`FTBSM_MAP_COUNT-1];
  reg [15:0] out_map_reg [0:`FTBSM_MAP_COUNT-1];
  reg [1:0] idle_high_impedance_reg;
  integer i;
  integer j;

  // ==========================================================
  // pin synchronisers: a change counts once stages 2 and 3 agree
  reg [3:0] sync1_reg;
  reg [3:0] sync2_reg;
  reg [3:0] sync3_reg;
  reg [3:0] pin_reg;
  reg bclk_prev_reg;
  wire bclk_rise = pin_reg[0] & ~bclk_prev_reg;
  wire bclk_fall = ~pin_reg[0] & bclk_prev_reg;
  wire fsync_now = pin_reg[1];
  wire din1 = pin_reg[2];
  wire din2 = pin_reg[3];

  always @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
      sync3_reg <= 4'h0;
      pin_reg <= 4'h0;
      bclk_prev_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      sync1_reg <= {second_flex_input_pin, first_flex_input_pin, tdm_fsync, tdm_bclk};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      for (j = 0; j < 4; j = j + 1)
        if (sync2_reg[j] == sync3_reg[j])
          pin_reg[j] <= sync3_reg[j];
      bclk_prev_reg <= pin_reg[0];
    end
  end

  // ==========================================================
  // frame position: fsync marks bit 0 of slot 0, msb first
  reg [7:0] bit_cnt_reg;
  reg [7:0] cur_bit;
  reg [7:0] next_bit;
  reg [7:0] in_sh1_reg;
  reg [7:0] in_sh2_reg;
  reg [7:0] cap1_reg;
  reg [7:0] cap2_reg;
  reg [4:0] cap_slot_reg;
  reg pend_reg;
  reg phase_reg;

  always @*
  begin
    cur_bit = fsync_now ? 8'h00 : bit_cnt_reg + 8'h01;
    next_bit = bit_cnt_reg + 8'h01;
  end

  // ==========================================================
  // input slot steering, two map entries per slot, one per cycle
  reg [15:0] in_map_sel;
  reg [7:0] in_byte;
  reg [8:0] in_ofs;

  always @*
  begin
    in_map_sel = in_map_reg[{phase_reg, cap_slot_reg}]; // [R13]
    in_byte = in_map_sel[`FTBSM_STREAM_BIT] ? cap2_reg : cap1_reg; // [R10]
    if (in_map_sel[`FTBSM_REVERSE_BIT])
      in_byte = rev8(in_byte);
    // stream bit forms index bit 3: channel 32+pos or 40+pos
    in_ofs = lane_ofs({in_map_sel[`FTBSM_STREAM_BIT],
      in_map_sel[`FTBSM_CHAN_POS_HI:`FTBSM_CHAN_POS_LO]},
      in_map_sel[`FTBSM_BYTE_POS_HI:`FTBSM_BYTE_POS_LO]); // [R01] [R02] [R03]
  end

  always @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      bit_cnt_reg <= 8'hff;
      in_sh1_reg <= 8'h00;
      in_sh2_reg <= 8'h00;
      cap1_reg <= 8'h00;
      cap2_reg <= 8'h00;
      cap_slot_reg <= 5'h00;
      pend_reg <= 1'b0;
      phase_reg <= 1'b0;
      flex_in_chan_data <= 512'h0;
    end
    else if (clk_en)
    begin
      if (bclk_rise)
      begin
        bit_cnt_reg <= cur_bit;
        in_sh1_reg <= {in_sh1_reg[6:0], din1};
        in_sh2_reg <= {in_sh2_reg[6:0], din2};
        if (cur_bit[2:0] == 3'h7)
        begin
          cap1_reg <= {in_sh1_reg[6:0], din1};
          cap2_reg <= {in_sh2_reg[6:0], din2};
          cap_slot_reg <= cur_bit[7:3];
          pend_reg <= 1'b1;
          phase_reg <= 1'b0;
        end
      end
      // bclk edges are several core cycles apart, so both phases finish
      if (pend_reg && !(bclk_rise && cur_bit[2:0] == 3'h7))
      begin
        if (in_map_sel[`FTBSM_ENABLE_BIT])
          flex_in_chan_data[in_ofs +: 8] <= in_byte; // [R11] [R05]
        phase_reg <= ~phase_reg;
        if (phase_reg)
          pend_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // output slots: byte loaded on the falling edge before its first bit
  reg [15:0] out_map_sel;
  reg [15:0] ld_byte;
  reg [1:0] ld_en;
  reg [7:0] ob;
  reg [15:0] out_sh_reg;
  reg [1:0] out_en_reg;
  integer p;

  always @*
  begin
    ld_byte = 16'h0000;
    ld_en = 2'b00;
    out_map_sel = 16'h0000;
    ob = 8'h00;
    for (p = 0; p < 2; p = p + 1)
    begin
      out_map_sel = out_map_reg[{p[0], next_bit[7:3]}]; // [R07]
      ob = ser_out_chan_data[lane_ofs(out_map_sel[5:2], out_map_sel[1:0]) +: 8]; // [R08]
      if (out_map_sel[`FTBSM_REVERSE_BIT])
        ob = rev8(ob);
      ld_byte[p*8 +: 8] = ob;
      ld_en[p] = out_map_sel[`FTBSM_ENABLE_BIT];
    end
  end

  always @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      out_sh_reg <= 16'h0000;
      out_en_reg <= 2'b00;
      first_flex_output_pin_o <= 1'b0;
      first_flex_output_pin_oe <= 1'b0;
      second_flex_output_pin_o <= 1'b0;
      second_flex_output_pin_oe <= 1'b0;
    end
    else if (clk_en && bclk_fall)
    begin
      if (next_bit[2:0] == 3'h0)
      begin
        out_sh_reg <= ld_byte;
        out_en_reg <= ld_en;
        first_flex_output_pin_o <= ld_en[0] & ld_byte[7];
        second_flex_output_pin_o <= ld_en[1] & ld_byte[15];
        first_flex_output_pin_oe <= ld_en[0] | ~idle_high_impedance_reg[0]; // [R12]
        second_flex_output_pin_oe <= ld_en[1] | ~idle_high_impedance_reg[1]; // [R12]
      end
      else
      begin
        out_sh_reg <= {out_sh_reg[14:8], 1'b0, out_sh_reg[6:0], 1'b0};
        first_flex_output_pin_o <= out_en_reg[0] & out_sh_reg[6];
        second_flex_output_pin_o <= out_en_reg[1] & out_sh_reg[14];
      end
    end
  end

  // ==========================================================
  // avalon slave: one wait cycle, then the access completes
  wire [15:0] word_idx = avs_address[ADDR_W-1:2];
  wire hit_in = (word_idx[15:6] == IN_BASE[15:6]);
  wire hit_out = (word_idx[15:6] == OUT_BASE[15:6]); // [R06]
  wire hit_chan = (word_idx[15:4] == CHAN_BASE[15:4]);
  wire hit_ctrl = (word_idx == CTRL_IDX);
  wire req = avs_read | avs_write;
  reg [31:0] rd_data;

  always @*
  begin
    rd_data = 32'h0;
    if (hit_in)
      rd_data = {16'h0000, in_map_reg[word_idx[5:0]]};
    else if (hit_out)
      rd_data = {16'h0000, out_map_reg[word_idx[5:0]]};
    else if (hit_chan)
      rd_data = flex_in_chan_data[{word_idx[3:0], 5'h00} +: 32];
    else if (hit_ctrl)
      rd_data = {30'h0, idle_high_impedance_reg};
  end

  always @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      for (i = 0; i < `FTBSM_MAP_COUNT; i = i + 1)
      begin
        in_map_reg[i] <= `FTBSM_MAP_RESET; // [R09]
        out_map_reg[i] <= `FTBSM_MAP_RESET; // [R09]
      end
      idle_high_impedance_reg <= `FTBSM_CTRL_RESET;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
    end
    else if (clk_en)
    begin
      if (req && avs_waitrequest)
      begin
        avs_waitrequest <= 1'b0;
        avs_readdata <= avs_read ? rd_data : 32'h0;
      end
      else
      begin
        avs_waitrequest <= 1'b1;
        // read data only stands in the answer cycle
        avs_readdata <= 32'h0;
        // unmapped and read-only words ignore writes
        if (avs_write && !avs_waitrequest)
        begin
          if (hit_in)
            in_map_reg[word_idx[5:0]] <= merge16(in_map_reg[word_idx[5:0]],
              avs_writedata, avs_byteenable);
          else if (hit_out)
            out_map_reg[word_idx[5:0]] <= merge16(out_map_reg[word_idx[5:0]],
              avs_writedata, avs_byteenable);
          else if (hit_ctrl && avs_byteenable[0])
            idle_high_impedance_reg <= avs_writedata[1:0];
        end
      end
    end
  end

endmodule // ftbsm_mapper

// File: inc/ftbsm_defs.vh
`ifndef FTBSM_DEFS_VH
`define FTBSM_DEFS_VH

// ==========================================================
// register map, word indices (byte address = 4 * index)
`define FTBSM_IN_MAP_BASE 16'hf300
`define FTBSM_OUT_MAP_BASE 16'hf380
`define FTBSM_CTRL_INDEX 16'hf3c0
`define FTBSM_CHAN_BASE_INDEX 16'hf3d0
`define FTBSM_MAP_COUNT 64
`define FTBSM_MAP_RESET 16'h0000
`define FTBSM_CTRL_RESET 2'h0

// ==========================================================
// slot map field positions
`define FTBSM_ENABLE_BIT 7
`define FTBSM_REVERSE_BIT 6
`define FTBSM_STREAM_BIT 5
`define FTBSM_CHAN_POS_HI 4
`define FTBSM_CHAN_POS_LO 2
`define FTBSM_BYTE_POS_HI 1
`define FTBSM_BYTE_POS_LO 0

// ==========================================================
// channel numbering and frame shape
`define FTBSM_FIRST_AUDIO_CHAN 32
`define FTBSM_SECOND_STREAM_CHAN 40
`define FTBSM_CHAN_COUNT 16
`define FTBSM_SLOTS_PER_PIN 32
`define FTBSM_BITS_PER_SLOT 8

`endif

// File: bench/ftbsm_assertions.sv
`timescale 1ns/100ps
// ==========================================================
// bus and pin checks
module ftbsm_checker #(
  parameter ADDR_W = 18
) (
  // clock and reset
  input wire core_clk,
  input wire reset_n,
  input wire clk_en,
  // register bus
  input wire [ADDR_W-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  // pins and channels
  input wire first_flex_output_pin_o,
  input wire first_flex_output_pin_oe,
  input wire second_flex_output_pin_o,
  input wire second_flex_output_pin_oe,
  input wire [511:0] flex_in_chan_data
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest && clk_en;
  endsequence
  sequence s_ans;
    avs_read && !avs_waitrequest;
  endsequence
  property p_answer;
    s_req |=> !avs_waitrequest;
  endproperty
  a_answer: assert property (p_answer)
    else $error("request not answered");
  property p_one;
    !avs_waitrequest && clk_en |=> avs_waitrequest;
  endproperty
  a_one: assert property (p_one)
    else $error("answer longer than one cycle");
  property p_rd_zero;
    avs_waitrequest |-> avs_readdata == 32'h0;
  endproperty
  a_rd_zero: assert property (p_rd_zero)
    else $error("read data outside answer");
  property p_map_w;
    s_ans |-> avs_address[17:2] < 16'hf300 || avs_address[17:2] > 16'hf3bf
      || avs_readdata[31:16] == 16'h0;
  endproperty
  a_map_w: assert property (p_map_w)
    else $error("map read wider than 16 bits");
  property p_unmap;
    s_ans ##0 avs_address[17:2] == 16'hf3e0 |-> avs_readdata == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap)
    else $error("unmapped read not zero");
  property p_rst;
    disable iff (1'b0) !reset_n |=> avs_waitrequest && flex_in_chan_data == 512'h0
      && !first_flex_output_pin_oe && !second_flex_output_pin_oe;
  endproperty
  a_rst: assert property (p_rst)
    else $error("state not cleared by reset");
  property p_idle1;
    !first_flex_output_pin_oe |-> !first_flex_output_pin_o;
  endproperty
  a_idle1: assert property (p_idle1)
    else $error("first pin data while released");
  property p_idle2;
    !second_flex_output_pin_oe |-> !second_flex_output_pin_o;
  endproperty
  a_idle2: assert property (p_idle2)
    else $error("second pin data while released");
endmodule // ftbsm_checker

bind ftbsm_mapper ftbsm_checker #(.ADDR_W(ADDR_W)) u_chk (.core_clk(core_clk),
  .reset_n(reset_n), .clk_en(clk_en), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .first_flex_output_pin_o(first_flex_output_pin_o),
  .first_flex_output_pin_oe(first_flex_output_pin_oe),
  .second_flex_output_pin_o(second_flex_output_pin_o),
  .second_flex_output_pin_oe(second_flex_output_pin_oe),
  .flex_in_chan_data(flex_in_chan_data));

// File: bench/ftbsm_tdm_end.sv
`timescale 1ns/100ps
// ==========================================================
// far tdm device
module ftbsm_tdm_end (
  // driven pins
  output logic bclk,
  output logic fsync,
  output logic d1,
  output logic d2,
  // watched pins
  input wire o1,
  input wire e1,
  input wire o2,
  input wire e2
);
  logic [255:0] c1, c2, v1, v2;
  initial
  begin
    {bclk, fsync, d1, d2} = 4'h0;
  end
  // clock stops between calls; data flips after release, no pull
  task automatic frame(input logic [255:0] a, input logic [255:0] b);
    for (int i = 255; i >= 0; i--)
    begin
      fsync = (i == 255);
      d1 = a[i];
      d2 = b[i];
      #150 bclk = 1'b1;
      c1[i] = o1;
      v1[i] = e1;
      c2[i] = o2;
      v2[i] = e2;
      #150 bclk = 1'b0;
    end
    fsync = 1'b0;
    d1 = !d1;
    d2 = !d2;
  endtask
endmodule // ftbsm_tdm_end

// File: bench/testbench.sv
`timescale 1ns/100ps
`include "ftbsm_defs.vh"
module testbench;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic [17:0] avs_address = 18'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [511:0] ser_out_chan_data = {448'h0, 32'h44556669, 32'hc3112233};
  logic [511:0] flex_in_chan_data;
  logic bclk, fsync, d1, d2, o1, e1, o2, e2;
  logic [31:0] q;
  int num_errors = 0;
  int total_checks = 0;
  always #10 core_clk = !core_clk;
  ftbsm_mapper dut (.core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .tdm_bclk(bclk), .tdm_fsync(fsync),
    .first_flex_input_pin(d1), .second_flex_input_pin(d2),
    .first_flex_output_pin_o(o1), .first_flex_output_pin_oe(e1),
    .second_flex_output_pin_o(o2), .second_flex_output_pin_oe(e2),
    .ser_out_chan_data(ser_out_chan_data), .flex_in_chan_data(flex_in_chan_data));
  ftbsm_tdm_end far (.bclk(bclk), .fsync(fsync), .d1(d1), .d2(d2),
    .o1(o1), .e1(e1), .o2(o2), .e2(e2));
  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [511:0] e, input logic [511:0] g);
    total_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // holds the request until waitrequest is sampled low
  task automatic bus(input logic w, input logic [15:0] i, input logic [31:0] d);
    int k;
    k = 0;
    avs_address <= {i, 2'b00};
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do
    begin
      @(posedge core_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 40);
    if (avs_waitrequest !== 1'b0)
    begin
      num_errors++;
      stop_test();
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [15:0] i, input logic [31:0] e);
    bus(1'b0, i, 32'h0);
    chk($sformatf("reg %h", i), e, q);
  endtask
  initial
  begin
    repeat (20) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    rd(`FTBSM_IN_MAP_BASE, 32'h0);
    rd(`FTBSM_OUT_MAP_BASE, 32'h0);
    rd(`FTBSM_OUT_MAP_BASE + 16'd63, 32'h0);
    bus(1'b1, `FTBSM_OUT_MAP_BASE + 16'd63, 32'hffffff7f);
    rd(`FTBSM_OUT_MAP_BASE + 16'd63, 32'hff7f);
    bus(1'b1, 16'hf3e0, 32'h1234);
    rd(16'hf3e0, 32'h0);
    // slot 5 of pin one stays unmapped and must be dropped
    bus(1'b1, `FTBSM_IN_MAP_BASE, 32'h80);
    // reversed byte on both sides, so a lost reverse shows
    bus(1'b1, `FTBSM_IN_MAP_BASE + 16'd37, 32'hff);
    bus(1'b1, `FTBSM_OUT_MAP_BASE, 32'h80);
    bus(1'b1, `FTBSM_OUT_MAP_BASE + 16'd33, 32'hc7);
    bus(1'b1, `FTBSM_CTRL_INDEX, 32'h2);
    repeat (2) far.frame({8'ha5, 32'h0, 8'h3c, 208'h0}, {40'h0, 8'h96, 208'h0});
    repeat (10) @(posedge core_clk);
    chk("channels", {32'h69, 448'h0, 32'ha5000000}, flex_in_chan_data);
    chk("pin1 data", {8'hc3, 248'h0}, far.c1);
    chk("pin1 enable", {256{1'b1}}, far.v1);
    chk("pin2 data", {8'h0, 8'h96, 240'h0}, far.c2);
    chk("pin2 enable", {8'h0, 8'hff, 240'h0}, far.v2);
    rd(`FTBSM_CHAN_BASE_INDEX + 16'd15, 32'h69);
    // reset in mid-run must clear maps, control and channels
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    rd(`FTBSM_OUT_MAP_BASE + 16'd33, 32'h0);
    rd(`FTBSM_IN_MAP_BASE + 16'd37, 32'h0);
    rd(`FTBSM_CTRL_INDEX, 32'h0);
    rd(`FTBSM_CHAN_BASE_INDEX + 16'd15, 32'h0);
    stop_test();
  end
endmodule // testbench
